// File: qcirq_pkg.sv
package qcirq_pkg;

    // ------------------------------------------------------------
    // Bus and data geometry
    // ------------------------------------------------------------
    localparam int QCIRQ_ADDR_W = 12;
    localparam int QCIRQ_DATA_W = 32;
    localparam int QCIRQ_NUM_QUEUES = 8;
    localparam int QCIRQ_NUM_STAT = 4;
    // Receive rollover bit n belongs to counter n plus this base
    localparam int QCIRQ_RX_CNT_BASE = 32;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] QCIRQ_OFS_QSTAT = 12'h1C0;
    localparam logic [11:0] QCIRQ_OFS_QSMASK = 12'h1C4;
    localparam logic [11:0] QCIRQ_OFS_OUSTAT = 12'h1C8;
    localparam logic [11:0] QCIRQ_OFS_OUMASK = 12'h1CC;
    localparam logic [11:0] QCIRQ_OFS_TXSTAT = 12'h1D0;
    localparam logic [11:0] QCIRQ_OFS_TXMASK = 12'h1D4;
    localparam logic [11:0] QCIRQ_OFS_RXSTAT = 12'h1D8;
    localparam logic [11:0] QCIRQ_OFS_RXMASK = 12'h1DC;
    localparam logic [11:0] QCIRQ_OFS_SUMMARY = 12'h1E8;

    // ------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] QCIRQ_RESET_VAL = 32'h0000_0000;
    localparam logic [31:0] QCIRQ_ALL_VALID = 32'hFFFF_FFFF;
    // Overflow/underrun pairs sit in the top two bits of each nibble
    localparam logic [31:0] QCIRQ_OU_VALID = 32'hCCCC_CCCC;
    localparam int QCIRQ_NIB_W = 4;
    localparam int QCIRQ_EV_EMPTY_RISE = 3;
    localparam int QCIRQ_EV_EMPTY_FALL = 2;
    localparam int QCIRQ_EV_A_RISE = 1;
    localparam int QCIRQ_EV_B_RISE = 0;
    localparam int QCIRQ_EV_OVERFLOW = 3;
    localparam int QCIRQ_EV_UNDERRUN = 2;
    localparam int QCIRQ_SUM_QSTAT = 19;
    localparam int QCIRQ_SUM_OU = 18;
    localparam int QCIRQ_SUM_RMON = 16;

    // Index of each status register in the sticky array
    localparam int QCIRQ_ST_QS = 0;
    localparam int QCIRQ_ST_OU = 1;
    localparam int QCIRQ_ST_TX = 2;
    localparam int QCIRQ_ST_RX = 3;

    // ------------------------------------------------------------
    // Register select
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        QCIRQ_SEL_QSTAT = 4'b0000,
        QCIRQ_SEL_QSMASK = 4'b0001,
        QCIRQ_SEL_OUSTAT = 4'b0010,
        QCIRQ_SEL_OUMASK = 4'b0011,
        QCIRQ_SEL_TXSTAT = 4'b0100,
        QCIRQ_SEL_TXMASK = 4'b0101,
        QCIRQ_SEL_RXSTAT = 4'b0110,
        QCIRQ_SEL_RXMASK = 4'b0111,
        QCIRQ_SEL_SUMMARY = 4'b1000,
        QCIRQ_SEL_NONE = 4'b1111
    } qcirq_sel_e;

endpackage

// File: qcirq_sticky.sv
`timescale 1ns/1ps
`default_nettype none

// Sticky status word: events set bits, reported bits are cleared
module qcirq_sticky #(
    parameter int W = 32,
    parameter logic [W-1:0] VALID = '1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Set and clear vectors
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    // Current status
    output logic [W-1:0] stat_o
);
    typedef struct packed {
        logic [W-1:0] stat;
    } qcirq_stk_s;

    qcirq_stk_s s_r;
    qcirq_stk_s s_nxt;

    // Set beats clear so an event in the clearing cycle survives
    always_comb begin
        s_nxt = s_r;
        s_nxt.stat = ((s_r.stat & ~clr_i) | set_i) & VALID;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign stat_o = s_r.stat;

    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        (set_i != '0) |=> ((stat_o & $past(set_i & VALID))
                           == $past(set_i & VALID));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost against a clear");

endmodule // qcirq_sticky

`default_nettype wire

// File: qcirq_regs.sv
// Overview of operation
// - Each mask bit enables the interrupt for the same status bit position.
// - A masked-off status bit still latches and clears, but raises nothing.
// - Transmit counter mask gates transmit rollover bits into the interrupt.
// - Queue q overflow/underrun at nibble q bits 3:2; other pairs read zero.
// - Overflow/underrun and both rollover status registers clear on read.
// - Transmit rollover bit n sets when transmit counter n rolls over.
// - Receive rollover bit n sets when receive counter n+32 rolls over.
// - Per queue: empty rise, empty fall, threshold A rise, B rise bits.
// - Summary bits follow their sources; reading the summary clears nothing.
`timescale 1ns/1ps
`default_nettype none

module qcirq_regs (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [qcirq_pkg::QCIRQ_ADDR_W-1:0] paddr,
    input wire logic [qcirq_pkg::QCIRQ_DATA_W-1:0] pwdata,
    output logic [qcirq_pkg::QCIRQ_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Queue manager levels and pulses
    input wire logic [qcirq_pkg::QCIRQ_NUM_QUEUES-1:0] queue_empty_flag,
    input wire logic [qcirq_pkg::QCIRQ_NUM_QUEUES-1:0] queue_thresh_a,
    input wire logic [qcirq_pkg::QCIRQ_NUM_QUEUES-1:0] queue_thresh_b,
    input wire logic [qcirq_pkg::QCIRQ_NUM_QUEUES-1:0] queue_overflow,
    input wire logic [qcirq_pkg::QCIRQ_NUM_QUEUES-1:0] queue_underrun,
    // Statistics counter rollover pulses
    input wire logic [qcirq_pkg::QCIRQ_DATA_W-1:0] tx_rollover,
    input wire logic [qcirq_pkg::QCIRQ_DATA_W-1:0] rx_rollover,
    // Host interrupt
    output logic irq
);
    import qcirq_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic primed;
        logic [QCIRQ_NUM_QUEUES-1:0] empty_q;
        logic [QCIRQ_NUM_QUEUES-1:0] tha_q;
        logic [QCIRQ_NUM_QUEUES-1:0] thb_q;
        logic [QCIRQ_DATA_W-1:0] qs_mask;
        logic [QCIRQ_DATA_W-1:0] ou_mask;
        logic [QCIRQ_DATA_W-1:0] tx_mask;
        logic [QCIRQ_DATA_W-1:0] rx_mask;
        logic [QCIRQ_DATA_W-1:0] summary;
        logic [QCIRQ_DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } qcirq_state_s;

    qcirq_state_s s_r;
    qcirq_state_s s_nxt;

    logic [QCIRQ_DATA_W-1:0] set_v [QCIRQ_NUM_STAT];
    logic [QCIRQ_DATA_W-1:0] clr_v [QCIRQ_NUM_STAT];
    logic [QCIRQ_DATA_W-1:0] stat_v [QCIRQ_NUM_STAT];
    logic [QCIRQ_DATA_W-1:0] qs_pend;
    logic [QCIRQ_DATA_W-1:0] ou_pend;
    logic [QCIRQ_DATA_W-1:0] tx_pend;
    logic [QCIRQ_DATA_W-1:0] rx_pend;
    logic apb_setup;
    logic apb_done;
    qcirq_sel_e setup_sel;
    qcirq_sel_e done_sel;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic qcirq_sel_e decode_sel(
        input logic [QCIRQ_ADDR_W-1:0] a);
        qcirq_sel_e r;
        case (a)
            QCIRQ_OFS_QSTAT: r = QCIRQ_SEL_QSTAT;
            QCIRQ_OFS_QSMASK: r = QCIRQ_SEL_QSMASK;
            QCIRQ_OFS_OUSTAT: r = QCIRQ_SEL_OUSTAT;
            QCIRQ_OFS_OUMASK: r = QCIRQ_SEL_OUMASK;
            QCIRQ_OFS_TXSTAT: r = QCIRQ_SEL_TXSTAT;
            QCIRQ_OFS_TXMASK: r = QCIRQ_SEL_TXMASK;
            QCIRQ_OFS_RXSTAT: r = QCIRQ_SEL_RXSTAT;
            QCIRQ_OFS_RXMASK: r = QCIRQ_SEL_RXMASK;
            QCIRQ_OFS_SUMMARY: r = QCIRQ_SEL_SUMMARY;
            default: r = QCIRQ_SEL_NONE;
        endcase
        return r;
    endfunction

    assign apb_setup = psel & ~penable;
    assign apb_done = psel & penable & s_r.pready;
    assign setup_sel = decode_sel(paddr);
    assign done_sel = decode_sel(paddr);

    // ------------------------------------------------------------
    // Event capture
    // ------------------------------------------------------------
    // Edges are only taken once the previous levels are valid, so
    // flags that sit high out of reset raise no false rise event
    genvar q;
    generate
        for (q = 0; q < QCIRQ_NUM_QUEUES; q++) begin : g_queue
            assign set_v[QCIRQ_ST_QS][q*QCIRQ_NIB_W+QCIRQ_EV_EMPTY_RISE] =
                s_r.primed & queue_empty_flag[q] & ~s_r.empty_q[q];
            assign set_v[QCIRQ_ST_QS][q*QCIRQ_NIB_W+QCIRQ_EV_EMPTY_FALL] =
                s_r.primed & ~queue_empty_flag[q] & s_r.empty_q[q];
            assign set_v[QCIRQ_ST_QS][q*QCIRQ_NIB_W+QCIRQ_EV_A_RISE] =
                s_r.primed & queue_thresh_a[q] & ~s_r.tha_q[q];
            assign set_v[QCIRQ_ST_QS][q*QCIRQ_NIB_W+QCIRQ_EV_B_RISE] =
                s_r.primed & queue_thresh_b[q] & ~s_r.thb_q[q];
            assign set_v[QCIRQ_ST_OU][q*QCIRQ_NIB_W+QCIRQ_EV_OVERFLOW] =
                queue_overflow[q];
            assign set_v[QCIRQ_ST_OU][q*QCIRQ_NIB_W+QCIRQ_EV_UNDERRUN] =
                queue_underrun[q];
            assign set_v[QCIRQ_ST_OU][q*QCIRQ_NIB_W+1:q*QCIRQ_NIB_W] =
                2'h0;
        end
    endgenerate

    // transmit counter n sets bit n
    assign set_v[QCIRQ_ST_TX] = tx_rollover;
    // receive counter n+32 arrives on bit n
    assign set_v[QCIRQ_ST_RX] = rx_rollover;

    // ------------------------------------------------------------
    // Status registers
    // ------------------------------------------------------------
    // Only the bits shown in the finished read are cleared; an event
    // landing between the setup and completion edges stays pending
    // latching ignores masks
    genvar k;
    generate
        for (k = 0; k < QCIRQ_NUM_STAT; k++) begin : g_stat
            qcirq_sticky #(
                .W(QCIRQ_DATA_W),
                .VALID((k == QCIRQ_ST_OU) ? QCIRQ_OU_VALID
                                          : QCIRQ_ALL_VALID)
            ) u_stat (
                .pclk(pclk),
                .presetn(presetn),
                .set_i(set_v[k]),
                .clr_i(clr_v[k]),
                .stat_o(stat_v[k])
            );
        end
    endgenerate

    // clear on read of each status register
    always_comb begin
        clr_v[QCIRQ_ST_QS] = QCIRQ_RESET_VAL;
        clr_v[QCIRQ_ST_OU] = QCIRQ_RESET_VAL;
        clr_v[QCIRQ_ST_TX] = QCIRQ_RESET_VAL;
        clr_v[QCIRQ_ST_RX] = QCIRQ_RESET_VAL;
        if (apb_done && !pwrite) begin
            case (done_sel)
                QCIRQ_SEL_QSTAT: clr_v[QCIRQ_ST_QS] = s_r.prdata;
                QCIRQ_SEL_OUSTAT: clr_v[QCIRQ_ST_OU] = s_r.prdata;
                QCIRQ_SEL_TXSTAT: clr_v[QCIRQ_ST_TX] = s_r.prdata;
                QCIRQ_SEL_RXSTAT: clr_v[QCIRQ_ST_RX] = s_r.prdata;
                default: ;
            endcase
        end
    end

    // one mask bit per status bit
    assign qs_pend = stat_v[QCIRQ_ST_QS] & s_r.qs_mask;
    assign ou_pend = stat_v[QCIRQ_ST_OU] & s_r.ou_mask;
    // transmit rollover gated by its mask
    assign tx_pend = stat_v[QCIRQ_ST_TX] & s_r.tx_mask;
    assign rx_pend = stat_v[QCIRQ_ST_RX] & s_r.rx_mask;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.primed = 1'b1;
        s_nxt.empty_q = queue_empty_flag;
        s_nxt.tha_q = queue_thresh_a;
        s_nxt.thb_q = queue_thresh_b;
        // summary mirrors sources, never cleared by its read
        s_nxt.summary = QCIRQ_RESET_VAL;
        s_nxt.summary[QCIRQ_SUM_QSTAT] = |qs_pend;
        s_nxt.summary[QCIRQ_SUM_OU] = |ou_pend;
        s_nxt.summary[QCIRQ_SUM_RMON] = |(tx_pend | rx_pend);
        s_nxt.irq = |(qs_pend | ou_pend | tx_pend | rx_pend);
        // No wait state: data is fetched at setup, shown in access
        s_nxt.pready = apb_setup;
        s_nxt.pslverr = apb_setup && (setup_sel == QCIRQ_SEL_NONE);
        if (apb_setup) begin
            case (setup_sel)
                QCIRQ_SEL_QSTAT: s_nxt.prdata = stat_v[QCIRQ_ST_QS];
                QCIRQ_SEL_QSMASK: s_nxt.prdata = s_r.qs_mask;
                QCIRQ_SEL_OUSTAT: s_nxt.prdata = stat_v[QCIRQ_ST_OU];
                QCIRQ_SEL_OUMASK: s_nxt.prdata = s_r.ou_mask;
                QCIRQ_SEL_TXSTAT: s_nxt.prdata = stat_v[QCIRQ_ST_TX];
                QCIRQ_SEL_TXMASK: s_nxt.prdata = s_r.tx_mask;
                QCIRQ_SEL_RXSTAT: s_nxt.prdata = stat_v[QCIRQ_ST_RX];
                QCIRQ_SEL_RXMASK: s_nxt.prdata = s_r.rx_mask;
                QCIRQ_SEL_SUMMARY: s_nxt.prdata = s_r.summary;
                default: s_nxt.prdata = QCIRQ_RESET_VAL;
            endcase
        end
        // Mask writes; writes to status registers are ignored
        if (apb_done && pwrite) begin
            case (done_sel)
                QCIRQ_SEL_QSMASK: s_nxt.qs_mask = pwdata;
                QCIRQ_SEL_OUMASK: s_nxt.ou_mask = pwdata;
                QCIRQ_SEL_TXMASK: s_nxt.tx_mask = pwdata;
                QCIRQ_SEL_RXMASK: s_nxt.rx_mask = pwdata;
                default: ;
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign irq = s_r.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_ou_read_done;
        psel && penable && pready && !pwrite &&
        paddr == QCIRQ_OFS_OUSTAT && set_v[QCIRQ_ST_OU] == '0;
    endsequence

    sequence s_empty_rise;
        s_r.primed && !queue_empty_flag[0] ##1 queue_empty_flag[0];
    endsequence

    property p_apb_wait;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready ##1 !pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait)
        else $error("access phase not answered after one cycle");

    property p_ou_clear;
        @(posedge pclk) disable iff (!presetn)
        s_ou_read_done |=> (stat_v[QCIRQ_ST_OU] & $past(prdata)) == '0;
    endproperty
    a_ou_clear: assert property (p_ou_clear)
        else $error("overflow status not cleared by its read");

    property p_ou_reserved;
        @(posedge pclk) disable iff (!presetn)
        (stat_v[QCIRQ_ST_OU] & ~QCIRQ_OU_VALID) == '0;
    endproperty
    a_ou_reserved: assert property (p_ou_reserved)
        else $error("reserved overflow bit set");

    property p_ou_q7;
        @(posedge pclk) disable iff (!presetn)
        queue_overflow[7] && queue_underrun[7] |=>
            stat_v[QCIRQ_ST_OU][31] && stat_v[QCIRQ_ST_OU][30];
    endproperty
    a_ou_q7: assert property (p_ou_q7)
        else $error("queue 7 overflow pair not at bits 31:30");

    property p_tx_set;
        @(posedge pclk) disable iff (!presetn)
        tx_rollover != '0 |=>
            (stat_v[QCIRQ_ST_TX] & $past(tx_rollover)) == $past(tx_rollover);
    endproperty
    a_tx_set: assert property (p_tx_set)
        else $error("transmit rollover not latched");

    property p_rx_set;
        @(posedge pclk) disable iff (!presetn)
        rx_rollover != '0 |=>
            (stat_v[QCIRQ_ST_RX] & $past(rx_rollover)) == $past(rx_rollover);
    endproperty
    a_rx_set: assert property (p_rx_set)
        else $error("receive rollover not latched");

    property p_empty_rise;
        @(posedge pclk) disable iff (!presetn)
        s_empty_rise |=> stat_v[QCIRQ_ST_QS][QCIRQ_EV_EMPTY_RISE];
    endproperty
    a_empty_rise: assert property (p_empty_rise)
        else $error("queue 0 empty rise not latched");

    property p_summary;
        @(posedge pclk) disable iff (!presetn)
        s_r.primed |=> s_r.summary[QCIRQ_SUM_OU] == $past(|ou_pend);
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary does not follow its source");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        ##1 irq == $past(|(qs_pend | ou_pend | tx_pend | rx_pend));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not follow masked status");

    property p_masked_quiet;
        @(posedge pclk) disable iff (!presetn)
        (s_r.qs_mask == '0 && s_r.ou_mask == '0 && s_r.tx_mask == '0 &&
         s_r.rx_mask == '0) |=> !irq;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("interrupt raised with all masks clear");

    property p_tx_mask;
        @(posedge pclk) disable iff (!presetn)
        tx_pend != '0 |=> irq;
    endproperty
    a_tx_mask: assert property (p_tx_mask)
        else $error("enabled transmit rollover gave no interrupt");

endmodule // qcirq_regs

`default_nettype wire

// File: qcirq_host.sv
`timescale 1ns/1ps
`default_nettype none

// APB host model: one transfer at a time, no wait limit of its own
module qcirq_host (
    // Clock
    input wire logic pclk,
    // APB request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [qcirq_pkg::QCIRQ_ADDR_W-1:0] paddr,
    output logic [qcirq_pkg::QCIRQ_DATA_W-1:0] pwdata,
    // APB answer
    input wire logic pready
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // Called just after a rising edge; request held until pready is seen
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the next call never re-drives psel in this step
        @(posedge pclk);
    endtask
endmodule // qcirq_host

`default_nettype wire

// File: qcirq_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
    n_errors++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end end

module qcirq_regs_tb;
    import qcirq_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, ev_tx, ev_rx, r;
    logic [7:0] q_empty, q_a, q_b, ev_ov, ev_un, e, a, b;
    logic [33:0] note;
    logic [33:0] exp_q[$];
    logic [11:0] masks[4] = '{QCIRQ_OFS_QSMASK, QCIRQ_OFS_OUMASK,
                              QCIRQ_OFS_TXMASK, QCIRQ_OFS_RXMASK};
    int n_errors = 0;
    int comparisons = 0;
    int seed = 32'hf75bda83;

    qcirq_host host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready));

    qcirq_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .queue_empty_flag(q_empty), .queue_thresh_a(q_a),
        .queue_thresh_b(q_b), .queue_overflow(ev_ov),
        .queue_underrun(ev_un), .tx_rollover(ev_tx), .rx_rollover(ev_rx),
        .irq(irq));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Read with its expected data and error noted for the monitor
    task automatic rd(input logic [11:0] ad, input logic [31:0] ex,
                      input logic er = 1'b0);
        exp_q.push_back({1'b1, er, ex});
        host.xfer(1'b0, ad, 32'h0000_0000);
    endtask

    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        exp_q.push_back({1'b0, 1'b0, 32'h0000_0000});
        host.xfer(1'b1, ad, d);
    endtask

    // One-cycle event pulses, then wait until the interrupt has settled
    task automatic ev(input logic [31:0] t, input logic [31:0] x,
                      input logic [7:0] o, input logic [7:0] u);
        ev_tx <= t;
        ev_rx <= x;
        ev_ov <= o;
        ev_un <= u;
        @(posedge pclk);
        ev_tx <= 32'h0000_0000;
        ev_rx <= 32'h0000_0000;
        ev_ov <= 8'h00;
        ev_un <= 8'h00;
        tick(2);
    endtask

    // Spread one bit per queue into bit pos of each nibble
    function automatic logic [31:0] nib(input logic [7:0] v, input int pos);
        nib = 32'h0000_0000;
        for (int q = 0; q < 8; q++) nib[4*q+pos] = v[q];
    endfunction

    task automatic wrap_up;
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, monitor and watchdog
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Oldest note is checked at each completing edge
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            note = exp_q.pop_front();
            `CHK(pslverr, note[32])
            if (note[33]) `CHK(prdata, note[31:0])
        end
    end

    initial begin
        tick(5000);
        n_errors++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {q_empty, q_a, q_b, ev_ov, ev_un} = '0;
        ev_tx = 32'h0000_0000;
        ev_rx = 32'h0000_0000;
        tick(6);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, then mask read-back
        for (int i = 0; i < 8; i++) rd(QCIRQ_OFS_QSTAT + 12'(4*i), 0);
        rd(12'h000, 32'h0000_0000, 1'b1);
        foreach (masks[i]) begin
            r = $random(seed);
            wr(masks[i], r);
            rd(masks[i], r);
            wr(masks[i], 32'h0000_0000);
        end
        // Transmit rollover: latches while masked off, status not writable
        r = $random(seed);
        ev(r, 32'h0000_0000, 8'h00, 8'h00);
        `CHK(irq, 1'b0)
        wr(QCIRQ_OFS_TXSTAT, 32'hFFFF_FFFF);
        wr(QCIRQ_OFS_TXMASK, ~r);
        tick(2);
        `CHK(irq, 1'b0)
        wr(QCIRQ_OFS_TXMASK, r);
        tick(2);
        `CHK(irq, |r)
        // Pending rollover shows in the summary's counter bit
        rd(QCIRQ_OFS_SUMMARY, 32'(|r) << QCIRQ_SUM_RMON);
        rd(QCIRQ_OFS_TXSTAT, r);
        tick(2);
        `CHK(irq, 1'b0)
        rd(QCIRQ_OFS_TXSTAT, 32'h0000_0000);
        wr(QCIRQ_OFS_TXMASK, 32'h0000_0000);
        // Receive rollover
        r = $random(seed);
        ev(32'h0000_0000, r, 8'h00, 8'h00);
        wr(QCIRQ_OFS_RXMASK, r);
        tick(2);
        `CHK(irq, |r)
        rd(QCIRQ_OFS_RXSTAT, r);
        rd(QCIRQ_OFS_RXSTAT, 32'h0000_0000);
        wr(QCIRQ_OFS_RXMASK, 32'h0000_0000);
        // Overflow and underrun pairs
        {a, b} = 16'($random(seed));
        ev(32'h0000_0000, 32'h0000_0000, a, b);
        wr(QCIRQ_OFS_OUMASK, 32'hFFFF_FFFF);
        tick(2);
        `CHK(irq, |{a, b})
        rd(QCIRQ_OFS_SUMMARY, 32'(|{a, b}) << QCIRQ_SUM_OU);
        rd(QCIRQ_OFS_OUSTAT, nib(a, 3) | nib(b, 2));
        rd(QCIRQ_OFS_OUSTAT, 32'h0000_0000);
        tick(2);
        `CHK(irq, 1'b0)
        wr(QCIRQ_OFS_OUMASK, 32'h0000_0000);
        // Queue edges and the summary that follows them
        wr(QCIRQ_OFS_QSMASK, 32'hFFFF_FFFF);
        {e, a, b} = 24'($random(seed));
        q_empty <= e;
        tick(3);
        rd(QCIRQ_OFS_SUMMARY, 32'(|e) << QCIRQ_SUM_QSTAT);
        rd(QCIRQ_OFS_SUMMARY, 32'(|e) << QCIRQ_SUM_QSTAT);
        rd(QCIRQ_OFS_QSTAT, nib(e, 3));
        tick(3);
        rd(QCIRQ_OFS_SUMMARY, 32'h0000_0000);
        q_empty <= 8'h00;
        tick(3);
        rd(QCIRQ_OFS_QSTAT, nib(e, 2));
        q_a <= a;
        q_b <= b;
        tick(3);
        rd(QCIRQ_OFS_QSTAT, nib(a, 1) | nib(b, 0));
        q_a <= 8'h00;
        q_b <= 8'h00;
        tick(3);
        rd(QCIRQ_OFS_QSTAT, 32'h0000_0000);
        tick(2);
        wrap_up();
    end
endmodule // qcirq_regs_tb

`default_nettype wire
